// File: verilog/rwd_cfg.svh
// constants for the reset, watchdog and interrupt control block
`ifndef RWD_CFG_SVH
`define RWD_CFG_SVH
`define RWD_DRIVE_BUS    7'h22
`define RWD_SAMPLE_BUS   7'h26
`define RWD_SP_RESET     16'h00FF
`define RWD_RST_VEC      16'hFFFE
`define RWD_VEC_TOP      16'hFFFC
`define RWD_IBIT         3
`define RWD_FRAME        3'h5
`define RWD_PREF         3'h3
`define RWD_NSRC         8
`define RWD_WD_W         18
`define RWD_WD_BUS_SHORT 8192
`define RWD_WD_BUS_LONG  262144
`define RWD_KTICK_MS     1
`define RWD_K_SHORT_MS   32
`define RWD_K_LONG_MS    256
`define RWD_C_POR        7
`define RWD_C_PIN        6
`define RWD_C_WDOG       5
`define RWD_C_ILOP       4
`define RWD_C_CLK        2
`define RWD_C_LOWV       1
`endif

// File: verilog/rwd_pkg.sv
// types for the reset, watchdog and interrupt control block
`default_nettype none
`include "rwd_cfg.svh"
package rwd_pkg;
   typedef enum logic [1:0] {
      RS_RUN   = 2'b00,
      RS_DRIVE = 2'b01,
      RS_WAIT  = 2'b10
   } rwd_rst_e;
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_PUSH = 3'b001,
      SQ_VEC  = 3'b010,
      SQ_PREF = 3'b011,
      SQ_POP  = 3'b100
   } rwd_seq_e;
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  a;
      logic [7:0]  x;
      logic [7:0]  ccb;
   } rwd_regs_s;
   typedef struct packed {
      rwd_rst_e                rst;
      logic [6:0]              rcnt;
      logic                    bus_ph;
      logic                    sys_rst;
      logic                    pin_oe_n;
      logic                    clk_self;
      logic [7:0]              pend;
      logic [7:0]              cause;
      logic                    wd_en;
      logic                    wd_clk;
      logic                    wd_to;
      logic                    lock1;
      logic                    lock2;
      logic [`RWD_WD_W-1:0]    wcnt;
      logic [`RWD_NSRC-1:0]    flags;
      logic                    ibit;
      logic [15:0]             sp;
      rwd_seq_e                seq;
      logic [2:0]              k;
      logic [15:0]             vaddr;
      rwd_regs_s               regs;
      logic [15:0]             maddr;
      logic [7:0]              mwdata;
      logic                    mwe;
      logic                    mre;
      logic                    pref;
      logic                    pc_load;
      logic                    regs_load;
      logic                    busy;
   } rwd_st_s;
endpackage
`default_nettype wire

// File: verilog/rwd_top.sv
// reset sequencer, watchdog and interrupt entry/return engine
// Summary of operation
// - drive reset pin low 34 bus cycles
// - sample pin 38 bus cycles after release
// - reset selects self-clock; bus is half rate
// - one cause bit per source, none debug
// - reset loads vector, SP 0x00FF, mask set
// - reset disables peripherals, pins hi-z inputs
// - watchdog enabled after every reset
// - cause record write clears watchdog counter
// - select bus clock or 1 kHz tick
// - 1 kHz timeouts 32 or 256 counts
// - bus timeouts 2^13 or 2^18, long default
// - overflow forces reset, records watchdog cause
// - option registers write-once, first write services
// - debug mode holds watchdog counter
// - bus clock: counter frozen during stop
// - 1 kHz: counter zeroed on stop
// - flag set; take if enabled and unmasked
// - finish instruction, stack, mask, vector, prefetch
// - frame low PC byte first, flags last
// - high index register never stacked
// - return unstacks reverse, prefetches three bytes
// - highest pending source serviced first
`timescale 1ns/1ns
`default_nettype none
`include "rwd_cfg.svh"
module rwd_top
   import rwd_pkg::*;
#(
   parameter int WD_BUS_SHORT = `RWD_WD_BUS_SHORT,
   parameter int WD_BUS_LONG  = `RWD_WD_BUS_LONG
) (
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // reset pin
   input  wire logic                 rstpin_in,
   output logic                      rstpin_out,
   output logic                      rstpin_oe_n,
   // other reset sources
   input  wire logic                 low_voltage_rst,
   input  wire logic                 ilop_rst,
   input  wire logic                 clk_loss_rst,
   input  wire logic                 bdm_rst,
   // system state
   output logic                      sys_reset,
   output logic                      periph_disable,
   output logic                      gpio_force_input,
   output logic                      gpio_pullup_off,
   input  wire logic                 clkgen_leave_self,
   output logic                      clkgen_self_mode,
   output logic                      bus_clk_phase,
   output logic [7:0]                reset_cause_record,
   // watchdog control
   input  wire logic                 cause_record_wr,
   input  wire logic                 opt1_wr,
   input  wire logic                 opt1_wdog_en,
   input  wire logic                 opt1_wdog_to,
   input  wire logic                 opt2_wr,
   input  wire logic                 opt2_wdog_clk,
   input  wire logic                 khz_tick,
   input  wire logic                 stop_mode,
   input  wire logic                 bdm_active,
   output logic                      watchdog_enable,
   output logic                      watchdog_clock_select,
   output logic                      watchdog_timeout_select,
   // interrupt sources
   input  wire logic [`RWD_NSRC-1:0] irq_event,
   input  wire logic [`RWD_NSRC-1:0] irq_enable,
   input  wire logic [`RWD_NSRC-1:0] irq_flag_clr,
   output logic [`RWD_NSRC-1:0]      irq_flags,
   // processor core
   input  wire logic                 instr_end,
   input  wire logic                 ret_req,
   input  wire logic                 cli_req,
   input  wire logic                 sei_req,
   input  wire rwd_regs_s            cpu_regs,
   output logic                      cpu_busy,
   output logic                      global_mask,
   output logic [15:0]               stack_ptr,
   output logic                      pc_load,
   output logic                      regs_load,
   output rwd_regs_s                 restore_regs,
   output logic                      prefetch,
   // memory port
   output logic [15:0]               mem_addr,
   output logic [7:0]                mem_wdata,
   output logic                      mem_we,
   output logic                      mem_re,
   input  wire logic [7:0]           mem_rdata
);
   localparam int K_SHORT = `RWD_K_SHORT_MS / `RWD_KTICK_MS;
   localparam int K_LONG  = `RWD_K_LONG_MS / `RWD_KTICK_MS;

   rwd_st_s              st;
   rwd_st_s              n;
   logic                 btick;
   logic                 tick;
   logic                 cnt_en;
   logic                 srv;
   logic                 ovf;
   logic                 trig;
   logic                 hit;
   logic [2:0]           pri;
   logic [2:0]           slot;
   logic [31:0]          lim;
   logic [7:0]           src;
   logic [`RWD_NSRC-1:0] qual;

   function automatic rwd_st_s img(input rwd_st_s s);
      rwd_st_s r;
      r          = s;
      r.rst      = RS_DRIVE;
      r.rcnt     = '0;
      r.sys_rst  = 1'b1;
      r.pin_oe_n = 1'b0;
      r.clk_self = 1'b1;
      r.wd_en    = 1'b1;
      r.wd_clk   = 1'b1;
      r.wd_to    = 1'b1;
      r.lock1    = 1'b0;
      r.lock2    = 1'b0;
      r.wcnt     = '0;
      r.flags    = '0;
      r.ibit     = 1'b1;
      r.sp       = `RWD_SP_RESET;
      r.seq      = SQ_IDLE;
      r.k        = '0;
      r.mwe      = 1'b0;
      r.mre      = 1'b0;
      r.pref     = 1'b0;
      r.pc_load  = 1'b0;
      r.regs_load = 1'b0;
      return r;
   endfunction

   always_comb begin
      n           = st;
      n.bus_ph    = ~st.bus_ph;
      btick       = st.bus_ph;
      n.mwe       = 1'b0;
      n.mre       = 1'b0;
      n.pref      = 1'b0;
      n.pc_load   = 1'b0;
      n.regs_load = 1'b0;
      n.flags     = (st.flags & ~irq_flag_clr) | irq_event;
      if (clkgen_leave_self)
         n.clk_self = 1'b0;
      // watchdog
      tick = st.wd_clk ? btick : khz_tick;
      if (st.wd_clk)
         lim = st.wd_to ? WD_BUS_LONG : WD_BUS_SHORT;
      else
         lim = st.wd_to ? K_LONG : K_SHORT;
      srv = cause_record_wr;
      if (opt1_wr && !st.lock1) begin
         n.wd_en = opt1_wdog_en;
         n.wd_to = opt1_wdog_to;
         n.lock1 = 1'b1;
         srv     = 1'b1;
      end
      if (opt2_wr && !st.lock2) begin
         n.wd_clk = opt2_wdog_clk;
         n.lock2  = 1'b1;
         srv      = 1'b1;
      end
      cnt_en = st.wd_en && !bdm_active && !stop_mode
               && st.rst == RS_RUN;
      ovf    = cnt_en && tick && !srv
               && st.wcnt == `RWD_WD_W'(lim - 1);
      if (srv || (stop_mode && !st.wd_clk))
         n.wcnt = '0;
      else if (cnt_en && tick)
         n.wcnt = st.wcnt + 1'b1;
      // reset sources
      src = '0;
      src[`RWD_C_LOWV] = low_voltage_rst;
      src[`RWD_C_WDOG] = ovf;
      src[`RWD_C_ILOP] = ilop_rst;
      src[`RWD_C_CLK]  = clk_loss_rst;
      n.pend = st.pend | src;
      trig   = (|src) || bdm_rst || (st.rst == RS_RUN && !rstpin_in);
      // interrupt priority, higher index wins
      qual = st.flags & irq_enable;
      hit  = |qual;
      pri  = '0;
      for (int i = 0; i < `RWD_NSRC; i++)
         if (qual[i])
            pri = 3'(i);
      slot = '0;
      case (st.rst)
         RS_DRIVE: begin
            if (btick) begin
               if (st.rcnt == `RWD_DRIVE_BUS - 7'h01) begin
                  n.rcnt     = '0;
                  n.rst      = RS_WAIT;
                  n.pin_oe_n = 1'b1;
               end else begin
                  n.rcnt = st.rcnt + 7'h01;
               end
            end
         end
         RS_WAIT: begin
            if (btick) begin
               if (st.rcnt == `RWD_SAMPLE_BUS - 7'h01) begin
                  n.cause = n.pend;
                  if (!rstpin_in && n.pend == '0)
                     n.cause[`RWD_C_PIN] = 1'b1;
                  n.pend    = '0;
                  n.rcnt    = '0;
                  n.rst     = RS_RUN;
                  n.sys_rst = 1'b0;
                  n.seq     = SQ_VEC;
                  n.vaddr   = `RWD_RST_VEC;
                  n.k       = '0;
               end else begin
                  n.rcnt = st.rcnt + 7'h01;
               end
            end
         end
         default: begin
            if (trig) begin
               n = img(n);
            end else begin
               case (st.seq)
                  SQ_IDLE: begin
                     if (cli_req)
                        n.ibit = 1'b0;
                     if (sei_req)
                        n.ibit = 1'b1;
                     if (ret_req) begin
                        n.seq = SQ_POP;
                        n.k   = '0;
                     end else if (instr_end && !st.ibit && hit) begin
                        n.seq  = SQ_PUSH;
                        n.k    = '0;
                        n.regs = cpu_regs;
                        n.vaddr = `RWD_VEC_TOP - {12'h000, pri, 1'b0};
                     end
                  end
                  SQ_PUSH: begin
                     // frame holds no high index byte
                     n.mwe   = 1'b1;
                     n.maddr = st.sp;
                     n.sp    = st.sp - 16'h0001;
                     n.k     = st.k + 3'h1;
                     case (st.k)
                        3'h0:    n.mwdata = st.regs.pc[7:0];
                        3'h1:    n.mwdata = st.regs.pc[15:8];
                        3'h2:    n.mwdata = st.regs.x;
                        3'h3:    n.mwdata = st.regs.a;
                        default: n.mwdata = {st.regs.ccb[7:4], st.ibit, st.regs.ccb[2:0]};
                     endcase
                     if (st.k == `RWD_FRAME - 3'h1) begin
                        n.seq  = SQ_VEC;
                        n.k    = '0;
                        n.ibit = 1'b1;
                     end
                  end
                  SQ_VEC: begin
                     if (st.k < 3'h2) begin
                        n.mre   = 1'b1;
                        n.maddr = st.vaddr + {13'h0000, st.k};
                        n.k     = st.k + 3'h1;
                     end
                     if (st.mre) begin
                        if (st.maddr[0] == st.vaddr[0])
                           n.regs.pc[15:8] = mem_rdata;
                        else
                           n.regs.pc[7:0] = mem_rdata;
                        if (st.k == 3'h2) begin
                           n.seq = SQ_PREF;
                           n.k   = '0;
                        end
                     end
                  end
                  SQ_PREF: begin
                     if (st.k < `RWD_PREF) begin
                        n.mre   = 1'b1;
                        n.pref  = 1'b1;
                        n.maddr = st.regs.pc + {13'h0000, st.k};
                        n.k     = st.k + 3'h1;
                        if (st.k == 3'h0)
                           n.pc_load = 1'b1;
                     end else begin
                        n.seq = SQ_IDLE;
                        n.k   = '0;
                     end
                  end
                  SQ_POP: begin
                     if (st.k < `RWD_FRAME) begin
                        n.mre   = 1'b1;
                        n.maddr = st.sp + 16'h0001 + {13'h0000, st.k};
                        n.k     = st.k + 3'h1;
                     end
                     if (st.mre) begin
                        slot = 3'(st.maddr - st.sp - 16'h0001);
                        case (slot)
                           3'h0:    n.regs.ccb = mem_rdata;
                           3'h1:    n.regs.a = mem_rdata;
                           3'h2:    n.regs.x = mem_rdata;
                           3'h3:    n.regs.pc[15:8] = mem_rdata;
                           default: n.regs.pc[7:0] = mem_rdata;
                        endcase
                        if (st.k == `RWD_FRAME) begin
                           n.sp        = st.sp + 16'(`RWD_FRAME);
                           n.ibit      = st.regs.ccb[`RWD_IBIT];
                           n.regs_load = 1'b1;
                           n.seq       = SQ_PREF;
                           n.k         = '0;
                        end
                     end
                  end
                  default: n.seq = SQ_IDLE;
               endcase
            end
         end
      endcase
      if (rst) begin
         n = img(n);
         n.bus_ph = 1'b0;
         n.regs   = '0;
         n.maddr  = '0;
         n.mwdata = '0;
         n.vaddr  = '0;
         n.cause  = '0;
         n.pend   = '0;
         n.pend[`RWD_C_POR] = 1'b1;
      end
      n.busy = n.sys_rst | (n.seq != SQ_IDLE);
   end

   always_ff @(posedge mclk) begin
      st <= n;
   end

   assign rstpin_out              = 1'b0;
   assign rstpin_oe_n             = st.pin_oe_n;
   assign sys_reset               = st.sys_rst;
   assign periph_disable          = st.sys_rst;
   assign gpio_force_input        = st.sys_rst;
   assign gpio_pullup_off         = st.sys_rst;
   assign clkgen_self_mode        = st.clk_self;
   assign bus_clk_phase           = st.bus_ph;
   assign reset_cause_record      = st.cause;
   assign watchdog_enable         = st.wd_en;
   assign watchdog_clock_select   = st.wd_clk;
   assign watchdog_timeout_select = st.wd_to;
   assign irq_flags               = st.flags;
   assign cpu_busy                = st.busy;
   assign global_mask             = st.ibit;
   assign stack_ptr               = st.sp;
   assign pc_load                 = st.pc_load;
   assign regs_load               = st.regs_load;
   assign restore_regs            = st.regs;
   assign prefetch                = st.pref;
   assign mem_addr                = st.maddr;
   assign mem_wdata               = st.mwdata;
   assign mem_we                  = st.mwe;
   assign mem_re                  = st.mre;

   property p_drive;
      @(posedge mclk) disable iff (rst)
      $rose(st.pin_oe_n) |-> $past(st.rcnt) == `RWD_DRIVE_BUS - 7'h01 && st.rst == RS_WAIT;
   endproperty
   a_drive: assert property (p_drive) else $error("pin released early");

   property p_sample;
      @(posedge mclk) disable iff (rst)
      $fell(st.sys_rst) |-> $past(st.rcnt) == `RWD_SAMPLE_BUS - 7'h01 && st.seq == SQ_VEC;
   endproperty
   a_sample: assert property (p_sample) else $error("pin sampled at wrong time");

   property p_init;
      @(posedge mclk) disable iff (rst)
      $fell(st.sys_rst) |-> st.sp == `RWD_SP_RESET && st.ibit && st.wd_en && st.wd_clk
                            && st.wd_to && !st.lock1 && st.vaddr == `RWD_RST_VEC;
   endproperty
   a_init: assert property (p_init) else $error("bad state after reset");

   property p_service;
      @(posedge mclk) disable iff (rst)
      cause_record_wr && st.rst == RS_RUN && !trig |=> st.wcnt == '0 && $stable(st.cause);
   endproperty
   a_service: assert property (p_service) else $error("service write missed");

   property p_bdm;
      @(posedge mclk) disable iff (rst)
      bdm_active && !srv && !stop_mode && st.rst == RS_RUN && !trig |=> $stable(st.wcnt);
   endproperty
   a_bdm: assert property (p_bdm) else $error("counter moved in debug");

   property p_stop_bus;
      @(posedge mclk) disable iff (rst)
      stop_mode && st.wd_clk && !srv && st.rst == RS_RUN && !trig |=> $stable(st.wcnt);
   endproperty
   a_stop_bus: assert property (p_stop_bus) else $error("counter moved in stop");

   property p_stop_khz;
      @(posedge mclk) disable iff (rst)
      stop_mode && !st.wd_clk && st.rst == RS_RUN && !trig |=> st.wcnt == '0;
   endproperty
   a_stop_khz: assert property (p_stop_khz) else $error("counter not zeroed");

   property p_ovf;
      @(posedge mclk) disable iff (rst)
      ovf |=> st.rst == RS_DRIVE && st.pend[`RWD_C_WDOG] && !st.pin_oe_n;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow did not reset");

   property p_push;
      @(posedge mclk) disable iff (rst)
      $rose(st.seq == SQ_PUSH) && !trig |=> st.mwe[*5] ##1 (!st.mwe && st.ibit
                                            && st.seq == SQ_VEC);
   endproperty
   a_push: assert property (p_push) else $error("bad stacking sequence");

   property p_masked;
      @(posedge mclk) disable iff (rst)
      st.ibit && st.seq == SQ_IDLE |=> st.seq != SQ_PUSH;
   endproperty
   a_masked: assert property (p_masked) else $error("masked interrupt taken");
endmodule
`default_nettype wire

// File: tb/rwd_mem_model.sv
// memory model standing for program store and stack behind the block
`timescale 1ns/1ns
`default_nettype none
module rwd_mem_model (
   // clock
   input  wire logic        mclk,
   // memory port
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   output logic [7:0]       mem_rdata
);
   logic [7:0] ram [0:65535];
   logic [7:0] junk_r;
   initial begin
      junk_r = 8'h0f;
      for (int i = 0; i < 65536; i++) ram[i] = i[7:0] ^ 8'h5a;
   end
   always @(posedge mclk) begin
      junk_r <= ~junk_r;
      if (mem_we) ram[mem_addr] <= mem_wdata;
   end
   // idle bus shows toggling junk, never the last byte
   assign mem_rdata = mem_re ? ram[mem_addr] : junk_r;
endmodule
`default_nettype wire

// File: tb/tb_reset_watchdog_interrupt_control.sv
// self-checking bench for the reset, watchdog and interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_reset_watchdog_interrupt_control;
   import rwd_pkg::*;
   logic        mclk, rst, rstpin_in, rstpin_out, rstpin_oe_n, low_voltage_rst, ilop_rst;
   logic        clk_loss_rst, ext_low;
   logic        bdm_rst, sys_reset, periph_disable, gpio_force_input, gpio_pullup_off;
   logic        clkgen_leave_self, clkgen_self_mode, bus_clk_phase, cause_record_wr, opt1_wr;
   logic        opt1_wdog_en, opt1_wdog_to, opt2_wr, opt2_wdog_clk, khz_tick, stop_mode;
   logic        bdm_active, watchdog_enable, watchdog_clock_select, watchdog_timeout_select;
   logic        instr_end, ret_req, cli_req, sei_req, cpu_busy, global_mask, pc_load;
   logic        regs_load, prefetch, mem_we, mem_re, seen_drv;
   logic [7:0]  reset_cause_record, irq_event, irq_enable, irq_flag_clr, irq_flags;
   logic [7:0]  mem_wdata, mem_rdata;
   logic [15:0] stack_ptr, mem_addr, pc_seen;
   logic [23:0] wq [$];
   rwd_regs_s   cpu_regs, restore_regs, rr_seen;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          pf_n = 0;
   // pin pulled up whenever the block lets go, unless held low outside
   assign rstpin_in = (rstpin_oe_n ? 1'b1 : rstpin_out) & ~ext_low;
   rwd_top #(.WD_BUS_SHORT(64), .WD_BUS_LONG(256)) uut (.mclk, .rst, .rstpin_in, .rstpin_out,
      .rstpin_oe_n, .low_voltage_rst, .ilop_rst, .clk_loss_rst, .bdm_rst, .sys_reset,
      .periph_disable, .gpio_force_input, .gpio_pullup_off, .clkgen_leave_self, .clkgen_self_mode,
      .bus_clk_phase, .reset_cause_record, .cause_record_wr, .opt1_wr, .opt1_wdog_en,
      .opt1_wdog_to, .opt2_wr, .opt2_wdog_clk, .khz_tick, .stop_mode, .bdm_active,
      .watchdog_enable, .watchdog_clock_select, .watchdog_timeout_select, .irq_event,
      .irq_enable, .irq_flag_clr, .irq_flags, .instr_end, .ret_req, .cli_req, .sei_req,
      .cpu_regs, .cpu_busy, .global_mask, .stack_ptr, .pc_load, .regs_load, .restore_regs,
      .prefetch, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
   rwd_mem_model mem (.mclk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (mem_we) wq.push_back({mem_addr, mem_wdata});
      if (pc_load) pc_seen = restore_regs.pc;
      if (regs_load) rr_seen = restore_regs;
      if (prefetch) pf_n++;
      if (rstpin_oe_n === 1'b0) seen_drv = 1'b1;
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (cpu_busy !== 1'b0 && n < 600);
      if (n >= 600) begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic s_reset;
      int n;
      @(posedge mclk) rst <= 1'b0;
      #1 chk({sys_reset, periph_disable, gpio_force_input, gpio_pullup_off}, 4'hf);
      chk({stack_ptr, global_mask, clkgen_self_mode, bus_clk_phase}, {16'h00ff, 3'b110});
      chk({watchdog_enable, watchdog_clock_select, watchdog_timeout_select}, 3'h7);
      n = 0;
      while (rstpin_oe_n === 1'b0 && n < 200) begin
         @(posedge mclk);
         #1 n++;
      end
      chk(n >= 66 && n <= 70, 1'b1);
      wait_idle();
      chk(reset_cause_record, 8'h80);
      chk(pc_seen, 16'ha4a5);
      chk(pf_n, 3);
   endtask
   task automatic s_causes;
      logic [31:0] tbl;
      tbl = 32'h0210_0400;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) clkgen_leave_self <= 1'b1;
         @(posedge mclk) clkgen_leave_self <= 1'b0;
         @(posedge mclk) {low_voltage_rst, ilop_rst, clk_loss_rst, bdm_rst} <= 4'h8 >> i;
         #1 chk(clkgen_self_mode, 1'b0);
         @(posedge mclk) {low_voltage_rst, ilop_rst, clk_loss_rst, bdm_rst} <= 4'h0;
         wait_idle();
         chk(reset_cause_record, tbl[31-8*i -: 8]);
         chk(clkgen_self_mode, 1'b1);
      end
   endtask
   task automatic s_wdog;
      int n;
      @(posedge mclk) {opt1_wr, opt1_wdog_en, opt1_wdog_to} <= 3'b110;
      @(posedge mclk) {opt1_wr, opt1_wdog_to} <= 2'b11;
      @(posedge mclk) opt1_wr <= 1'b0;
      #1 chk({watchdog_enable, watchdog_timeout_select}, 2'b10);
      seen_drv = 1'b0;
      // software servicing for several timeouts, then debug and stop holds
      repeat (5) begin
         repeat (100) @(posedge mclk);
         cause_record_wr <= 1'b1;
         @(posedge mclk) cause_record_wr <= 1'b0;
      end
      bdm_active <= 1'b1;
      repeat (300) @(posedge mclk);
      {bdm_active, stop_mode} <= 2'b01;
      repeat (300) @(posedge mclk);
      stop_mode <= 1'b0;
      #1 chk({seen_drv, reset_cause_record}, 9'h000);
      @(posedge mclk) cause_record_wr <= 1'b1;
      @(posedge mclk) cause_record_wr <= 1'b0;
      n = 0;
      while (rstpin_oe_n !== 1'b0 && n < 400) begin
         @(posedge mclk);
         #1 n++;
      end
      chk(n >= 124 && n <= 132, 1'b1);
      wait_idle();
      chk(reset_cause_record, 8'h20);
      chk({watchdog_enable, watchdog_clock_select, watchdog_timeout_select}, 3'h7);
   endtask
   task automatic s_irq;
      logic [39:0] frame;
      frame = 40'h3412_7856_c0;
      cpu_regs <= {16'h1234, 8'h56, 8'h78, 8'hc0};
      {irq_event, irq_enable} <= 16'h2828;
      @(posedge mclk) {irq_event, instr_end} <= 9'h001;
      @(posedge mclk) instr_end <= 1'b0;
      #1 chk({cpu_busy, irq_flags}, 9'h028);
      @(posedge mclk) cli_req <= 1'b1;
      @(posedge mclk) cli_req <= 1'b0;
      @(posedge mclk) instr_end <= 1'b1;
      wq.delete();
      pf_n = 0;
      @(posedge mclk) instr_end <= 1'b0;
      wait_idle();
      chk(wq.size(), 5);
      for (int i = 0; i < 5; i++) chk(wq[i], {16'h00ff - i[15:0], frame[39-8*i -: 8]});
      chk({pc_seen, stack_ptr, global_mask}, {16'ha8a9, 16'h00fa, 1'b1});
      chk(pf_n, 3);
      @(posedge mclk) irq_flag_clr <= 8'h20;
      @(posedge mclk) {irq_flag_clr, ret_req} <= 9'h001;
      @(posedge mclk) ret_req <= 1'b0;
      wait_idle();
      chk(irq_flags, 8'h08);
      chk({rr_seen, stack_ptr, global_mask}, {40'h1234_5678_c0, 16'h00ff, 1'b0});
      chk(pf_n, 6);
      @(posedge mclk) sei_req <= 1'b1;
      @(posedge mclk) sei_req <= 1'b0;
      #1 chk(global_mask, 1'b1);
   endtask
   // pin held low from outside until the sample point
   task automatic s_pin;
      int n;
      @(posedge mclk) ext_low <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (sys_reset !== 1'b0 && n < 300);
      ext_low <= 1'b0;
      chk(n >= 142 && n <= 148, 1'b1);
      wait_idle();
      chk(reset_cause_record, 8'h40);
   endtask
   task automatic khz_pulse;
      @(posedge mclk) khz_tick <= 1'b1;
      @(posedge mclk) khz_tick <= 1'b0;
   endtask
   // slow tick source: stop zeroes the count, short limit is 32 ticks
   task automatic s_khz;
      int n;
      @(posedge mclk) {opt1_wr, opt1_wdog_to, opt2_wr, opt2_wdog_clk} <= 4'b1010;
      @(posedge mclk) {opt1_wr, opt2_wr} <= 2'b00;
      #1 chk({watchdog_enable, watchdog_clock_select, watchdog_timeout_select}, 3'h4);
      repeat (20) khz_pulse();
      stop_mode <= 1'b1;
      khz_pulse();
      stop_mode <= 1'b0;
      n = 0;
      while (rstpin_oe_n !== 1'b0 && n < 40) begin
         khz_pulse();
         #1 n++;
      end
      chk(n, 32);
      wait_idle();
      chk(reset_cause_record, 8'h20);
   endtask
   initial begin
      {rst, opt1_wdog_en, opt1_wdog_to} = 3'b111;
      {low_voltage_rst, ilop_rst, clk_loss_rst, bdm_rst, clkgen_leave_self, cause_record_wr} = '0;
      {opt1_wr, opt2_wr, opt2_wdog_clk, khz_tick, stop_mode, bdm_active} = '0;
      {instr_end, ret_req, cli_req, sei_req, seen_drv, ext_low} = '0;
      {irq_event, irq_enable, irq_flag_clr} = '0;
      cpu_regs = '0;
      repeat (16) @(posedge mclk);
      s_reset();
      s_causes();
      s_wdog();
      s_irq();
      s_pin();
      s_khz();
      summarize();
   end
endmodule
`default_nettype wire
